// ### sbio_io_unit.sv
// bus-phase i/o instruction unit with classic wishbone slave
// assumes: pins are open-collector, wired by the surroundings;
// script fetch engine reads o_fetch_addr on o_fetch_go
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sbio_map.svh"
module sbio_io_unit (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_bsy_in,
  input wire logic i_sel_in,
  input wire logic i_io_in,
  input wire logic [7:0] i_data_in,
  output logic o_bsy_out,
  output logic o_bsy_oe,
  output logic o_sel_out,
  output logic o_sel_oe,
  output logic o_io_out,
  output logic o_io_oe,
  output logic [7:0] o_data_out,
  output logic o_data_oe,
  output logic o_ack_out,
  output logic o_ack_oe,
  output logic o_atn_out,
  output logic o_atn_oe,
  output logic o_dir_en,
  output logic [31:0] o_fetch_addr,
  output logic o_fetch_go
);
  localparam int FREE_CYC =
    (`SBIO_BUS_FREE_NS + `SBIO_CLK_NS - 1) / `SBIO_CLK_NS;
  localparam int ARB_CYC = (`SBIO_ARB_NS + `SBIO_CLK_NS - 1) / `SBIO_CLK_NS;
  localparam logic [4:0] SEL_SETTLE = `SBIO_SEL_SETTLE;

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  function automatic logic [7:0] higher(input logic [7:0] own);
    logic [7:0] m;
    m = own - 8'h01;
    return ~(own | m);
  endfunction : higher

  function automatic logic bad_op(input logic [31:0] w, input logic tgt);
    logic [2:0] op;
    op = w[`SBIO_OPC_HI:`SBIO_OPC_LO];
    return (op > `SBIO_OP_CLR) ||
      (w[`SBIO_SELATN_BIT] && (tgt || op != `SBIO_OP_SEL));
  endfunction : bad_op

  function automatic logic [31:0] rd(input sbio_pkg::sbio_regs_type s,
      input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `SBIO_A_CTRL0: v[`SBIO_ROLE_REG_BIT] = s.role_tgt;
      `SBIO_A_OWNID: v[7:0] = s.own_id;
      `SBIO_A_TEST4: v[`SBIO_LOOP_BIT] = s.loopback;
      `SBIO_A_DSP: v = s.dsp;
      `SBIO_A_SCRIPT_POINTER_SAVE: v = s.script_pointer_save;
      `SBIO_A_CMD: v = s.cmd;
      `SBIO_A_BUS_OUTPUT_CONTROL_LATCH: begin
        v[`SBIO_ACK_BIT] = s.bus_output_control_latch_ack;
        v[`SBIO_ATN_BIT] = s.bus_output_control_latch_atn;
      end
      `SBIO_A_STAT: begin
        v[`SBIO_ST_BUSY] = (s.st != sbio_pkg::SBIO_S_IDLE);
        v[`SBIO_ST_ILL] = s.illegal;
        v[`SBIO_ST_ALT] = s.alt;
        v[`SBIO_ST_DONE] = s.done;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : rd

  // ---------------------------------------------
  // pins and bus-free timing
  // ---------------------------------------------
  sbio_pkg::sbio_regs_type r;
  sbio_pkg::sbio_regs_type n;
  logic [10:0] pins_s;
  logic bsy_s;
  logic sel_s;
  logic io_s;
  logic [7:0] data_s;
  logic bus_free;
  logic hit;
  logic start;
  logic [31:0] w;
  logic [2:0] opc;
  logic tgt;
  logic bad;
  logic us;
  logic arb_end;
  logic lost;

  sbio_sync #(.W(11)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_pins({i_data_in, i_io_in, i_sel_in, i_bsy_in}),
    .o_pins(pins_s)
  );
  assign bsy_s = pins_s[0];
  assign sel_s = pins_s[1];
  assign io_s = pins_s[2];
  assign data_s = pins_s[10:3];

  sbio_bus_free #(.CYCLES(FREE_CYC)) u_free (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_idle(!bsy_s && !sel_s),
    .o_free(bus_free)
  );

  assign hit = i_wb_cyc && i_wb_stb && r.ack;
  assign w = merge(r.cmd, i_wb_dat, i_wb_sel);
  assign opc = w[`SBIO_OPC_HI:`SBIO_OPC_LO];
  assign tgt = r.role_tgt || w[`SBIO_ROLE_BIT];
  assign bad = bad_op(w, tgt);
  assign start = hit && i_wb_we && (i_wb_adr == `SBIO_A_CMD) &&
    (r.st == sbio_pkg::SBIO_S_IDLE);
  assign us = sel_s && !bsy_s && (|(data_s & r.own_id));
  assign arb_end = (r.st == sbio_pkg::SBIO_S_ARB) &&
    (r.arb_cnt == 5'(ARB_CYC));
  assign lost = |(data_s & higher(r.own_id));

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    logic fin;
    logic jmp;
    fin = 1'b0;
    jmp = 1'b0;
    n = r;
    n.go = 1'b0;
    n.ack = i_wb_cyc && i_wb_stb && !r.ack;
    if (!r.ack) begin
      n.dat = rd(r, i_wb_adr);
    end
    if (hit && i_wb_we) begin
      case (i_wb_adr)
        `SBIO_A_CTRL0: if (i_wb_sel[0]) begin
          n.role_tgt = i_wb_dat[`SBIO_ROLE_REG_BIT];
        end
        `SBIO_A_OWNID: if (i_wb_sel[0]) begin
          n.own_id = i_wb_dat[7:0];
        end
        `SBIO_A_TEST4: if (i_wb_sel[0]) begin
          n.loopback = i_wb_dat[`SBIO_LOOP_BIT];
        end
        `SBIO_A_DSP: n.dsp = merge(r.dsp, i_wb_dat, i_wb_sel);
        `SBIO_A_SCRIPT_POINTER_SAVE: n.script_pointer_save = merge(r.script_pointer_save, i_wb_dat, i_wb_sel);
        `SBIO_A_BUS_OUTPUT_CONTROL_LATCH: if (i_wb_sel[0]) begin
          n.bus_output_control_latch_ack = i_wb_dat[`SBIO_ACK_BIT];
          n.bus_output_control_latch_atn = i_wb_dat[`SBIO_ATN_BIT];
        end
        `SBIO_A_STAT: if (i_wb_sel[0]) begin
          n.illegal = r.illegal && !i_wb_dat[`SBIO_ST_ILL];
          n.alt = r.alt && !i_wb_dat[`SBIO_ST_ALT];
          n.done = r.done && !i_wb_dat[`SBIO_ST_DONE];
        end
        default: ;
      endcase
    end
    if (start) begin
      n.cmd = w;
      if (w[`SBIO_ROLE_BIT]) begin
        n.role_tgt = 1'b1;
      end
      if (bad) begin
        n.illegal = 1'b1;
      end else begin
        unique case (opc)
          `SBIO_OP_SEL: begin
            n.st = sbio_pkg::SBIO_S_ARBW;
          end
          `SBIO_OP_DISC: begin
            if (tgt) begin
              n.bsy_o = 1'b0;
              n.sel_o = 1'b0;
              n.io_o = 1'b0;
              n.data_oe = 1'b0;
              n.drive_en = 1'b0;
              n.bus_output_control_latch_ack = 1'b0;
              n.bus_output_control_latch_atn = 1'b0;
              fin = 1'b1;
            end else begin
              n.st = sbio_pkg::SBIO_S_WDISC;
            end
          end
          `SBIO_OP_WAIT: n.st = sbio_pkg::SBIO_S_WSEL;
          `SBIO_OP_SET: begin
            n.bus_output_control_latch_ack = r.bus_output_control_latch_ack || w[`SBIO_ACK_BIT];
            n.bus_output_control_latch_atn = r.bus_output_control_latch_atn || w[`SBIO_ATN_BIT];
            n.drive_en = 1'b1;
            fin = 1'b1;
          end
          `SBIO_OP_CLR: begin
            n.bus_output_control_latch_ack = r.bus_output_control_latch_ack && !w[`SBIO_ACK_BIT];
            n.bus_output_control_latch_atn = r.bus_output_control_latch_atn && !w[`SBIO_ATN_BIT];
            fin = 1'b1;
          end
          default: n.illegal = 1'b1;
        endcase
      end
    end
    unique case (r.st)
      sbio_pkg::SBIO_S_IDLE: ;
      sbio_pkg::SBIO_S_ARBW: begin
        if (us) begin
          n.role_tgt = !io_s;
          n.bsy_o = 1'b1;
          n.drive_en = 1'b1;
          jmp = 1'b1;
          fin = 1'b1;
        end else if (bus_free) begin
          n.bsy_o = 1'b1;
          n.data_o = r.own_id;
          n.data_oe = 1'b1;
          n.drive_en = 1'b1;
          n.arb_cnt = 5'h00;
          n.st = sbio_pkg::SBIO_S_ARB;
        end
      end
      sbio_pkg::SBIO_S_ARB: begin
        n.arb_cnt = r.arb_cnt + 5'h01;
        if (arb_end) begin
          n.arb_cnt = 5'h00;
          if (lost) begin
            n.bsy_o = 1'b0;
            n.data_oe = 1'b0;
            n.st = sbio_pkg::SBIO_S_ARBW;
          end else begin
            n.sel_o = 1'b1;
            n.data_o = r.own_id | r.cmd[`SBIO_DEST_HI:`SBIO_DEST_LO];
            n.io_o = r.role_tgt;
            if (!r.role_tgt && r.cmd[`SBIO_SELATN_BIT]) begin
              n.bus_output_control_latch_atn = 1'b1;
            end
            n.st = sbio_pkg::SBIO_S_SEL;
          end
        end
      end
      sbio_pkg::SBIO_S_SEL: begin
        if (r.arb_cnt != SEL_SETTLE) begin
          n.bsy_o = 1'b0;
          n.arb_cnt = r.arb_cnt + 5'h01;
        end else if (bsy_s) begin
          n.sel_o = 1'b0;
          n.data_oe = 1'b0;
          n.bsy_o = r.role_tgt;
          fin = 1'b1;
        end
      end
      sbio_pkg::SBIO_S_WSEL: begin
        if (us) begin
          n.bsy_o = 1'b1;
          n.drive_en = 1'b1;
          n.role_tgt = !io_s;
          jmp = (r.role_tgt == io_s);
          fin = 1'b1;
        end
      end
      sbio_pkg::SBIO_S_WDISC: begin
        if (bus_free) begin
          fin = 1'b1;
        end
      end
      default: n.st = sbio_pkg::SBIO_S_IDLE;
    endcase
    if (fin) begin
      n.st = sbio_pkg::SBIO_S_IDLE;
      n.done = 1'b1;
      n.go = 1'b1;
      if (jmp) begin
        n.alt = 1'b1;
        n.dsp = r.script_pointer_save;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign o_wb_dat = r.dat;
  assign o_wb_ack = r.ack;
  assign o_bsy_out = r.bsy_o;
  assign o_bsy_oe = r.bsy_o;
  assign o_sel_out = r.sel_o;
  assign o_sel_oe = r.sel_o;
  assign o_io_out = r.io_o;
  assign o_io_oe = r.io_o;
  assign o_data_out = r.data_o;
  assign o_data_oe = r.data_oe;
  assign o_ack_out = r.bus_output_control_latch_ack;
  assign o_ack_oe = r.drive_en && (!r.role_tgt || r.loopback);
  assign o_atn_out = r.bus_output_control_latch_atn;
  assign o_atn_oe = r.drive_en && (!r.role_tgt || r.loopback);
  assign o_dir_en = r.drive_en;
  assign o_fetch_addr = r.dsp;
  assign o_fetch_go = r.go;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  a_ack_drive_gate: assert property (
    o_ack_oe |-> (!r.role_tgt || r.loopback))
    else $error("ack driven in target role without loopback");
  a_illegal_halts: assert property (
    start && opc > `SBIO_OP_CLR |=> r.illegal && !o_fetch_go &&
      r.st == sbio_pkg::SBIO_S_IDLE)
    else $error("reserved opcode not flagged");
  a_atn_misuse: assert property (
    start && w[`SBIO_SELATN_BIT] && (tgt || opc != `SBIO_OP_SEL)
      |=> r.illegal)
    else $error("attention bit misuse not flagged");
  a_set_ack_bit: assert property (
    start && !bad && opc == `SBIO_OP_SET && w[`SBIO_ACK_BIT]
      |=> r.bus_output_control_latch_ack && o_fetch_go)
    else $error("set did not raise ack");
  a_clear_ack_bit: assert property (
    start && !bad && opc == `SBIO_OP_CLR && w[`SBIO_ACK_BIT]
      |=> !r.bus_output_control_latch_ack ##1 !r.bus_output_control_latch_ack || r.st != sbio_pkg::SBIO_S_IDLE)
    else $error("clear did not drop ack");
  a_disc_release: assert property (
    start && !bad && tgt && opc == `SBIO_OP_DISC
      |=> !o_bsy_oe && !o_sel_oe && !o_data_oe && !o_dir_en)
    else $error("disconnect left outputs driven");
  a_role_bit_set: assert property (
    start && w[`SBIO_ROLE_BIT] |=> r.role_tgt)
    else $error("role bit did not set target role");
  a_lost_retries: assert property (
    arb_end && lost |=> r.st == sbio_pkg::SBIO_S_ARBW && !o_bsy_oe &&
      $stable(r.illegal))
    else $error("lost arbitration not retried quietly");
  a_alt_jump_addr: assert property (
    r.st == sbio_pkg::SBIO_S_WSEL && us && (r.role_tgt == io_s)
      |=> o_fetch_go && r.alt && o_fetch_addr == $past(r.script_pointer_save))
    else $error("alternate address not taken");
  a_wdisc_stall: assert property (
    r.st == sbio_pkg::SBIO_S_WDISC && (bsy_s || sel_s)
      |=> r.st == sbio_pkg::SBIO_S_WDISC [*4])
    else $error("wait disconnect ended before bus free time");
  a_selatn_raise: assert property (
    arb_end && !lost && !r.role_tgt && r.cmd[`SBIO_SELATN_BIT]
      |=> r.bus_output_control_latch_atn && o_sel_oe)
    else $error("attention not raised for selection");
endmodule : sbio_io_unit
`default_nettype wire

// ### sbio_map.svh
// offsets, field positions and timing for the bus-phase i/o unit
// assumes: included by bare name, after the package where types matter
`ifndef SBIO_MAP_SVH
`define SBIO_MAP_SVH
`define SBIO_A_CTRL0 8'h00
`define SBIO_A_OWNID 8'h04
`define SBIO_A_TEST4 8'h08
`define SBIO_A_DSP 8'h0C
`define SBIO_A_SCRIPT_POINTER_SAVE 8'h10
`define SBIO_A_CMD 8'h14
`define SBIO_A_BUS_OUTPUT_CONTROL_LATCH 8'h18
`define SBIO_A_STAT 8'h1C
`define SBIO_ROLE_REG_BIT 0
`define SBIO_LOOP_BIT 1
`define SBIO_OPC_HI 29
`define SBIO_OPC_LO 27
`define SBIO_SELATN_BIT 24
`define SBIO_DEST_HI 23
`define SBIO_DEST_LO 16
`define SBIO_ROLE_BIT 10
`define SBIO_ACK_BIT 6
`define SBIO_ATN_BIT 3
`define SBIO_OP_SEL 3'h0
`define SBIO_OP_DISC 3'h1
`define SBIO_OP_WAIT 3'h2
`define SBIO_OP_SET 3'h3
`define SBIO_OP_CLR 3'h4
`define SBIO_ST_BUSY 0
`define SBIO_ST_ILL 1
`define SBIO_ST_ALT 2
`define SBIO_ST_DONE 3
`define SBIO_CLK_NS 100
`define SBIO_BUS_FREE_NS 400
`define SBIO_ARB_NS 2400
`define SBIO_SEL_SETTLE 5'h03
`endif

// ### sbio_pkg.sv
// types of the bus-phase i/o unit
// assumes: nothing
package sbio_pkg;
  typedef enum logic [2:0] {
    SBIO_S_IDLE = 3'h0,
    SBIO_S_ARBW = 3'h1,
    SBIO_S_ARB = 3'h2,
    SBIO_S_SEL = 3'h3,
    SBIO_S_WSEL = 3'h4,
    SBIO_S_WDISC = 3'h5
  } sbio_state_type;

  typedef struct packed {
    sbio_state_type st;
    logic [7:0] own_id;
    logic role_tgt;
    logic loopback;
    logic [31:0] dsp;
    logic [31:0] script_pointer_save;
    logic [31:0] cmd;
    logic bus_output_control_latch_ack;
    logic bus_output_control_latch_atn;
    logic illegal;
    logic done;
    logic alt;
    logic [4:0] arb_cnt;
    logic bsy_o;
    logic sel_o;
    logic io_o;
    logic [7:0] data_o;
    logic data_oe;
    logic drive_en;
    logic go;
    logic ack;
    logic [31:0] dat;
  } sbio_regs_type;
endpackage : sbio_pkg

// ### sbio_sync.sv
// two-flop synchroniser for a vector of pin levels
// assumes: bits are independent levels, no bus coherence needed
`timescale 1ns/1ps
`default_nettype none
module sbio_sync #(
  parameter int W = 11
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_pins,
  output var logic [W-1:0] o_pins
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sbio_sync_type;
  sbio_sync_type r;
  sbio_sync_type n;

  always_comb begin
    n = r;
    n.s1 = i_pins;
    n.s2 = r.s1;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_pins = r.s2;
endmodule : sbio_sync
`default_nettype wire

// ### sbio_bus_free.sv
// bus-free detector: idle level held for a minimum number of cycles
// assumes: i_idle is already synchronised to i_ref_clk
`timescale 1ns/1ps
`default_nettype none
module sbio_bus_free #(
  parameter int CYCLES = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_idle,
  output var logic o_free
);
  localparam int W = $clog2(CYCLES + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic free;
  } sbio_free_type;
  sbio_free_type r;
  sbio_free_type n;

  always_comb begin
    n = r;
    if (!i_idle) begin
      n.cnt = '0;
    end else if (r.cnt != W'(CYCLES)) begin
      n.cnt = r.cnt + W'(1);
    end
    n.free = i_idle && (n.cnt == W'(CYCLES));
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_free = r.free;
endmodule : sbio_bus_free
`default_nettype wire

// ### sbio_far_end.sv
// far-end bus device: answers selection, selects or reselects the unit
// assumes: lines are wired-or, 1 = asserted, released lines read 0
`timescale 1ns/1ps
`default_nettype none
module sbio_far_end #(
  parameter logic [7:0] FAR_ID = 8'h02,
  parameter int DELAY = 3
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [2:0] i_mode,
  input wire logic [7:0] i_unit_id,
  input wire logic i_bsy_bus,
  input wire logic i_sel_bus,
  input wire logic [7:0] i_data_bus,
  output logic o_bsy,
  output logic o_sel,
  output logic o_io,
  output logic [7:0] o_data
);
  logic [3:0] cnt;
  logic done;
  // ----------------------------------------
  // modes: 0 idle, 1 answer, 2 select, 3 reselect, 4 busy
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_mode == 3'h0) begin
      {o_bsy, o_sel, o_io, o_data, cnt, done} <= '0;
    end else if (i_mode == 3'h1) begin
      if (i_sel_bus && !o_sel && (i_data_bus & FAR_ID) != 8'h00) begin
        cnt <= cnt + 4'h1;
      end
      if (cnt == 4'(DELAY)) begin
        o_bsy <= 1'b1;
      end
    end else if (i_mode == 3'h4) begin
      o_bsy <= 1'b1;
    end else begin
      o_bsy <= 1'b0;
      o_sel <= !done;
      o_io <= (i_mode == 3'h3) && !done;
      o_data <= done ? 8'h00 : (FAR_ID | i_unit_id);
      if (o_sel && i_bsy_bus) begin
        done <= 1'b1;
      end
    end
  end
endmodule : sbio_far_end
`default_nettype wire

// ### scsi_bus_io_instruction_unit_test.sv
// self-checking bench of the bus-phase i/o unit
// assumes: far-end model on the bus, wishbone master in the bench
`timescale 1ns/1ps
`default_nettype none
`include "sbio_map.svh"
module scsi_bus_io_instruction_unit_test;
  localparam logic [31:0] SEQ = 32'h0000_0100;
  localparam logic [31:0] ALT = 32'h0000_2000;
  localparam logic [7:0] UID = 8'h80;
  int num_errors = 0;
  int checks_done = 0;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0;
  logic [2:0] far_mode = 3'h0;
  logic [31:0] o_wb_dat, o_fetch_addr;
  logic o_wb_ack, o_fetch_go, o_dir_en, o_data_oe;
  logic o_bsy_out, o_bsy_oe, o_sel_out, o_sel_oe, o_io_out, o_io_oe;
  logic o_ack_out, o_ack_oe, o_atn_out, o_atn_oe;
  logic [7:0] o_data_out, far_data, data_w, seen_data;
  logic far_bsy, far_sel, far_io, bsy_w, sel_w, io_w, seen_atn;
  assign bsy_w = (o_bsy_oe & o_bsy_out) | far_bsy;
  assign sel_w = (o_sel_oe & o_sel_out) | far_sel;
  assign io_w = (o_io_oe & o_io_out) | far_io;
  assign data_w = (o_data_oe ? o_data_out : 8'h00) | far_data;
  sbio_io_unit sbio_io_unit_i (
    .i_ref_clk, .i_sys_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_bsy_in(bsy_w),
    .i_sel_in(sel_w), .i_io_in(io_w), .i_data_in(data_w), .o_bsy_out,
    .o_bsy_oe, .o_sel_out, .o_sel_oe, .o_io_out, .o_io_oe, .o_data_out,
    .o_data_oe, .o_ack_out, .o_ack_oe, .o_atn_out, .o_atn_oe, .o_dir_en,
    .o_fetch_addr, .o_fetch_go
  );
  sbio_far_end #(.FAR_ID(8'h02), .DELAY(3)) sbio_far_end_i (
    .i_ref_clk, .i_sys_rst, .i_mode(far_mode), .i_unit_id(UID),
    .i_bsy_bus(bsy_w), .i_sel_bus(sel_w), .i_data_bus(data_w),
    .o_bsy(far_bsy), .o_sel(far_sel), .o_io(far_io), .o_data(far_data)
  );
  always #50 i_ref_clk = ~i_ref_clk;
  // last attention and id seen while the unit selects
  always @(negedge i_ref_clk) begin
    if (o_sel_oe && o_sel_out && !far_sel) begin
      seen_atn = o_atn_out & o_atn_oe;
      seen_data = o_data_out;
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp, input string w);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, w, seen, exp);
    end
  endtask : check
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task do_reset;
    @(posedge i_ref_clk);
    i_sys_rst <= 1'b1;
    far_mode <= 3'h0;
    repeat (6) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
  endtask : do_reset
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d,
          input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= s;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    if (o_wb_ack !== 1'b1) check(32'h0, 32'h1, "bus answer");
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
  endtask : wb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [31:0] e, input string w);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    check(q, e, w);
  endtask : rd_chk
  task start(input logic [2:0] op, input logic [31:0] flags);
    wr(`SBIO_A_DSP, SEQ);
    wr(`SBIO_A_SCRIPT_POINTER_SAVE, ALT);
    wr(`SBIO_A_CMD, {2'h1, op, 27'h0} | flags);
  endtask : start
  task wait_go(input int lim, output int n);
    n = 0;
    do begin
      @(negedge i_ref_clk);
      n++;
    end while (o_fetch_go !== 1'b1 && n < lim);
  endtask : wait_go
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    logic [31:0] q;
    rd_chk(`SBIO_A_CTRL0, 32'h0, "role reset");
    rd_chk(`SBIO_A_BUS_OUTPUT_CONTROL_LATCH, 32'h0, "latch reset");
    rd_chk(`SBIO_A_STAT, 32'h0, "status reset");
    wb(1'b1, 8'h40, 32'h1234_5678, 4'hF, q);
    rd_chk(8'h40, 32'h0, "unmapped");
    wb(1'b1, `SBIO_A_DSP, 32'hFFFF_FFFF, 4'h3, q);
    rd_chk(`SBIO_A_DSP, 32'h0000_FFFF, "byte enables");
    wr(`SBIO_A_OWNID, {24'h0, UID});
    rd_chk(`SBIO_A_OWNID, {24'h0, UID}, "own id");
    $display("test regs done");
  endtask : t_regs
  task t_setclr;
    int n;
    start(`SBIO_OP_SET, 32'h48);
    wait_go(5, n);
    check(o_fetch_addr, SEQ, "set next");
    check({o_ack_out, o_ack_oe, o_atn_out, o_atn_oe}, 4'hF, "drive");
    rd_chk(`SBIO_A_BUS_OUTPUT_CONTROL_LATCH, 32'h48, "set latch");
    start(`SBIO_OP_CLR, 32'h40);
    wait_go(5, n);
    check(o_fetch_addr, SEQ, "clear next");
    check({o_ack_out, o_atn_out}, 2'b01, "after clear");
    rd_chk(`SBIO_A_BUS_OUTPUT_CONTROL_LATCH, 32'h08, "clear latch");
    wr(`SBIO_A_CTRL0, 32'h1);
    @(negedge i_ref_clk);
    check(o_atn_oe, 1'b0, "target no drive");
    wr(`SBIO_A_TEST4, 32'h2);
    @(negedge i_ref_clk);
    check(o_atn_oe, 1'b1, "loopback drive");
    wr(`SBIO_A_TEST4, 32'h0);
    wr(`SBIO_A_CTRL0, 32'h0);
    start(`SBIO_OP_CLR, 32'h08);
    wait_go(5, n);
    rd_chk(`SBIO_A_BUS_OUTPUT_CONTROL_LATCH, 32'h0, "atn cleared");
    start(`SBIO_OP_DISC, 32'h0400);
    wait_go(5, n);
    rd_chk(`SBIO_A_CTRL0, 32'h1, "role bit");
    wr(`SBIO_A_CTRL0, 32'h0);
    $display("test set clear done");
  endtask : t_setclr
  task t_illegal;
    int n;
    logic [31:0] q;
    for (int r = 0; r < 2; r++) begin
      wr(`SBIO_A_CTRL0, 32'(r));
      for (int op = 5; op < 8; op++) begin
        start(3'(op), 32'h0);
        wait_go(4, n);
        check(32'(n), 32'h4, "no fetch");
        wb(1'b0, `SBIO_A_STAT, 32'h0, 4'hF, q);
        check(q & 32'h2, 32'h2, "illegal flag");
        rd_chk(`SBIO_A_SCRIPT_POINTER_SAVE, ALT, "save word");
        wr(`SBIO_A_STAT, 32'hE);
      end
    end
    wr(`SBIO_A_CTRL0, 32'h0);
    start(`SBIO_OP_SET, 32'h0100_0040);
    wait_go(4, n);
    check(32'(n), 32'h4, "atn bit no fetch");
    rd_chk(`SBIO_A_BUS_OUTPUT_CONTROL_LATCH, 32'h0, "not executed");
    wr(`SBIO_A_STAT, 32'hE);
    $display("test illegal done");
  endtask : t_illegal
  task t_select;
    int n;
    @(posedge i_ref_clk) far_mode <= 3'h1;
    start(`SBIO_OP_SEL, 32'h0102_0000);
    wait_go(300, n);
    check(32'(n < 300), 32'h1, "select won");
    check(o_fetch_addr, SEQ, "select next");
    check({seen_atn, seen_data}, 9'h182, "selection");
    start(`SBIO_OP_DISC, 32'h0);
    wait_go(20, n);
    check(32'(n), 32'h14, "stall busy");
    @(posedge i_ref_clk) far_mode <= 3'h0;
    wait_go(40, n);
    check(32'(n >= 4 && n < 40), 32'h1, "bus free");
    check(o_fetch_addr, SEQ, "free next");
    $display("test select done");
  endtask : t_select
  task t_selfirst;
    int n;
    do_reset();
    wr(`SBIO_A_OWNID, {24'h0, UID});
    @(posedge i_ref_clk) far_mode <= 3'h4;
    start(`SBIO_OP_SEL, 32'h0002_0000);
    repeat (5) @(posedge i_ref_clk);
    far_mode <= 3'h2;
    wait_go(60, n);
    check(o_fetch_addr, ALT, "alternate");
    rd_chk(`SBIO_A_CTRL0, 32'h1, "now target");
    @(posedge i_ref_clk) far_mode <= 3'h0;
    start(`SBIO_OP_DISC, 32'h0);
    wait_go(5, n);
    check(32'(n < 5), 32'h1, "disc fetch");
    check({o_bsy_oe, o_sel_oe, o_io_oe, o_data_oe, o_ack_oe, o_atn_oe,
           o_dir_en}, 7'h0, "released");
    @(posedge i_ref_clk) far_mode <= 3'h1;
    start(`SBIO_OP_SEL, 32'h0002_0000);
    wait_go(300, n);
    check(o_fetch_addr, SEQ, "reselect next");
    check({seen_atn, seen_data, o_io_out, o_bsy_oe}, 11'h20B, "resel");
    @(posedge i_ref_clk) far_mode <= 3'h0;
    $display("test selected first done");
  endtask : t_selfirst
  task t_waits;
    int n;
    logic [2:0] m;
    for (int i = 0; i < 4; i++) begin
      m = (i == 1 || i == 2) ? 3'h3 : 3'h2;
      do_reset();
      wr(`SBIO_A_OWNID, {24'h0, UID});
      wr(`SBIO_A_CTRL0, 32'(i < 2));
      start(`SBIO_OP_WAIT, 32'h0);
      repeat (3) @(posedge i_ref_clk);
      far_mode <= m;
      wait_go(60, n);
      check(o_fetch_addr, (i % 2 == 1) ? ALT : SEQ, "wait");
      @(posedge i_ref_clk) far_mode <= 3'h0;
      rd_chk(`SBIO_A_CTRL0, 32'(m == 3'h2), "wait role");
    end
    $display("test waits done");
  endtask : t_waits
  initial begin
    repeat (8000) @(posedge i_ref_clk);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    t_regs();
    t_setclr();
    t_illegal();
    t_select();
    t_selfirst();
    t_waits();
    conclude();
  end
endmodule : scsi_bus_io_instruction_unit_test
`default_nettype wire
